// ### verilog/lfsup_pkg.sv
// package: codes, commands, states and timing of the lift drive fault supervisor
//
// Functional notes
// - quick-start held over 20 s: abort, 780
// - quick-start during travel: abort, 781
// - release dropped in travel, if masked: 799
// - CAN errors: stop delay, then release check
// - velocity mode heartbeat missing or mistimed: 800
// - position mode: control or encoder heartbeat: 800
// - drive-cycle commands out of order: 820
// - no Disable Operation within timeout: 831
// - no Shutdown while brakes close: 832
// - no Disable Voltage at travel end: 833
// - position mode: encoder info object never written: 840
// - nine-hundred errors cleared only by power-off
// - after-switch-on fault: 905, 60 s, wait-off
// - no chopper-monitor signal at startup: 906
// - feedback unit contact open at switch-on: 908
// - chopper/resistor contact open at switch-on: 910
// - resistor overload 150 % in 120 s: 911
package lfsup_pkg;
    // ******************************
    // timing
    // ******************************
    localparam longint unsigned CLK_HZ      = 64'h0000_0000_0131_2D00;
    localparam longint unsigned QS_TIME_S   = 64'h0000_0000_0000_0014;
    localparam longint unsigned OFF_TIME_S  = 64'h0000_0000_0000_003C;
    localparam longint unsigned OVL_WIN_S   = 64'h0000_0000_0000_0078;
    localparam longint unsigned OVL_PCT     = 64'h0000_0000_0000_0096;
    localparam longint unsigned QS_CYC      = QS_TIME_S * CLK_HZ;
    localparam longint unsigned OFF_CYC     = OFF_TIME_S * CLK_HZ;
    localparam longint unsigned OVL_WIN_CYC = OVL_WIN_S * CLK_HZ;
    localparam logic [31:0]     STOP_DLY_CYC = 32'h0000_0400;
    localparam logic [3:0]      STARTUP_CYC  = 4'h4;
    // ******************************
    // error numbers
    // ******************************
    localparam logic [9:0] E_QS_LONG  = 10'h30C;
    localparam logic [9:0] E_QS_TRAV  = 10'h30D;
    localparam logic [9:0] E_RELEASE  = 10'h31F;
    localparam logic [9:0] E_HB       = 10'h320;
    localparam logic [9:0] E_ORDER    = 10'h334;
    localparam logic [9:0] E_TO_DISOP = 10'h33F;
    localparam logic [9:0] E_TO_SHUT  = 10'h340;
    localparam logic [9:0] E_TO_DISV  = 10'h341;
    localparam logic [9:0] E_ENC_INFO = 10'h348;
    localparam logic [9:0] E_HW_SW    = 10'h389;
    localparam logic [9:0] E_CHOPPER  = 10'h38A;
    localparam logic [9:0] E_FBU      = 10'h38C;
    localparam logic [9:0] E_BRK      = 10'h38E;
    localparam logic [9:0] E_OVERLOAD = 10'h38F;
    // ******************************
    // controller registers
    // ******************************
    localparam logic [7:0] A_CTRL  = 8'h00;
    localparam logic [7:0] A_CMD   = 8'h04;
    localparam logic [7:0] A_HBPER = 8'h08;
    localparam logic [7:0] A_STAT  = 8'h0C;
    localparam logic [7:0] A_ISTAT = 8'h10;
    localparam logic [7:0] A_IMASK = 8'h14;
    localparam logic [31:0] HBPER_RST = 32'h0000_4E20;
    // ******************************
    // types
    // ******************************
    typedef enum logic [2:0] {
        CMD_NONE, CMD_SHUTDOWN, CMD_SWITCH_ON, CMD_ENABLE_OP,
        CMD_DISABLE_OP, CMD_DISABLE_VOLT, CMD_FAULT_RESET, CMD_ENC_INFO
    } lfsup_cmd_t;
    typedef enum logic [3:0] {
        ST_STARTUP, ST_DISABLED, ST_READY, ST_ON, ST_TRAVEL, ST_STOPPING,
        ST_STOP_DELAY, ST_RELEASE_CHECK, ST_FATAL, ST_WAIT_OFF
    } lfsup_state_t;
endpackage

// ### verilog/lfsup_link_if.sv
// interface: link between lift control and drive fault supervisor
`timescale 1ns/10ps
interface lfsup_link_if;
    import lfsup_pkg::*;
    logic         quick_start;
    logic         drive_release_input;
    logic         hb_ctrl;
    logic         cmd_valid;
    lfsup_cmd_t   cmd;
    logic [9:0]   err_code;
    logic         err_new;
    lfsup_state_t state;
    modport dev (input quick_start, drive_release_input, hb_ctrl, cmd_valid, cmd,
                 output err_code, err_new, state);
    modport ctl (output quick_start, drive_release_input, hb_ctrl, cmd_valid, cmd,
                 input err_code, err_new, state);
endinterface

// ### verilog/lfsup_device.sv
// drive end: fault supervisor of the lift frequency inverter
`timescale 1ns/10ps
module lfsup_device import lfsup_pkg::*; #(
    parameter logic [31:0] QS_LIM   = 32'(QS_CYC),
    parameter logic [31:0] OFF_LIM  = 32'(OFF_CYC),
    parameter logic [31:0] OVL_WIN  = 32'(OVL_WIN_CYC),
    parameter logic [31:0] OVL_RATE = 32'(OVL_WIN_CYC / 4)
) (
    // clock and reset
    input  wire logic   pclk,
    input  wire logic   presetn,
    // link to the control
    lfsup_link_if.dev   lk,
    // configuration
    input  wire logic        cfg_qs_en,
    input  wire logic        cfg_mask_799,
    input  wire logic        cfg_pos_mode,
    input  wire logic [31:0] cfg_hb_min,
    input  wire logic [31:0] cfg_hb_max,
    input  wire logic [31:0] cfg_t_cmd,
    // plant pins
    input  wire logic   chopper_monitor_input,
    input  wire logic   fbu_contact,
    input  wire logic   brk_contact,
    input  wire logic   hw_fault,
    input  wire logic   hb_enc,
    input  wire logic   travel_end,
    input  wire logic   brake_load,
    // status
    output logic        drive_off
);
    // ******************************
    // pin synchronisers
    // ******************************
    logic [6:0] s1_ff, s2_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_ff <= '0;
            s2_ff <= '0;
        end else begin
            s1_ff <= {chopper_monitor_input, fbu_contact, brk_contact, hw_fault, hb_enc, travel_end, brake_load};
            s2_ff <= s1_ff;
        end
    end
    logic chop_s, fbu_s, brk_s, hwf_s, henc_s, tend_s, bload_s;
    assign {chop_s, fbu_s, brk_s, hwf_s, henc_s, tend_s, bload_s} = s2_ff;
    logic henc_d_ff, tend_d_ff, qs_d_ff, rel_d_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            henc_d_ff <= 1'b0;
            tend_d_ff <= 1'b0;
            qs_d_ff   <= 1'b0;
            rel_d_ff  <= 1'b0;
        end else begin
            henc_d_ff <= henc_s;
            tend_d_ff <= tend_s;
            qs_d_ff   <= lk.quick_start;
            rel_d_ff  <= lk.drive_release_input;
        end
    end
    logic henc_p, tend_p;
    assign henc_p = henc_s & ~henc_d_ff;
    assign tend_p = tend_s & ~tend_d_ff;

    // ******************************
    // state and counters
    // ******************************
    lfsup_state_t state_ff, nxt_state;
    logic [31:0] qs_cnt_ff, hbc_cnt_ff, hbe_cnt_ff, cmd_cnt_ff, dly_cnt_ff;
    logic [31:0] win_cnt_ff, ovl_cnt_ff;
    logic [3:0]  su_cnt_ff;
    logic        cmd_wait_ff, enc_info_ff, can_err_ff;
    logic        hb_live, in_fatal, run;
    assign in_fatal = (state_ff == ST_FATAL) || (state_ff == ST_WAIT_OFF);
    assign run      = (state_ff != ST_STARTUP) && !in_fatal;
    assign hb_live  = run && (state_ff != ST_RELEASE_CHECK);

    // ******************************
    // fault detection, worst class first
    // ******************************
    logic       hit, fatal, can;
    logic [9:0] num;
    logic       cv;
    logic       ok_cmd;
    assign cv = lk.cmd_valid;
    always_comb begin
        ok_cmd = 1'b1;
        case (state_ff)
            ST_DISABLED: ok_cmd = lk.cmd == CMD_SHUTDOWN;
            ST_READY:    ok_cmd = lk.cmd == CMD_SWITCH_ON || lk.cmd == CMD_DISABLE_VOLT;
            ST_ON:       ok_cmd = lk.cmd == CMD_ENABLE_OP || lk.cmd == CMD_SHUTDOWN;
            ST_TRAVEL:   ok_cmd = lk.cmd == CMD_DISABLE_OP;
            ST_STOPPING: ok_cmd = lk.cmd == CMD_SHUTDOWN;
            default:     ok_cmd = 1'b1;
        endcase
        if (lk.cmd == CMD_ENC_INFO || lk.cmd == CMD_FAULT_RESET || lk.cmd == CMD_NONE) begin
            ok_cmd = 1'b1;
        end
    end
    always_comb begin
        hit   = 1'b1;
        fatal = 1'b1;
        can   = 1'b0;
        num   = '0;
        if (in_fatal) begin
            hit = 1'b0;
        end else if (state_ff == ST_STARTUP && su_cnt_ff == STARTUP_CYC && !chop_s) begin
            num = E_CHOPPER;
        end else if (state_ff == ST_STARTUP && su_cnt_ff == STARTUP_CYC && !fbu_s) begin
            num = E_FBU;
        end else if (state_ff == ST_STARTUP && su_cnt_ff == STARTUP_CYC && !brk_s) begin
            num = E_BRK;
        end else if (state_ff != ST_STARTUP && hwf_s) begin
            num = E_HW_SW;
        end else if (state_ff != ST_STARTUP && ovl_cnt_ff > 32'(longint'(OVL_RATE) * OVL_PCT / 100)) begin
            num = E_OVERLOAD;
        end else begin
            fatal = 1'b0;
            can   = 1'b1;
            if (hb_live && ((lk.hb_ctrl && hbc_cnt_ff < cfg_hb_min) || hbc_cnt_ff >= cfg_hb_max)) begin
                num = E_HB;
            end else if (hb_live && cfg_pos_mode &&
                         ((henc_p && hbe_cnt_ff < cfg_hb_min) || hbe_cnt_ff >= cfg_hb_max)) begin
                num = E_HB;
            end else if (run && cv && !ok_cmd) begin
                num = E_ORDER;
            end else if (run && cv && lk.cmd == CMD_ENABLE_OP && cfg_pos_mode && !enc_info_ff) begin
                num = E_ENC_INFO;
            end else if (cmd_wait_ff && cmd_cnt_ff >= cfg_t_cmd && state_ff == ST_TRAVEL) begin
                num = E_TO_DISOP;
            end else if (cmd_wait_ff && cmd_cnt_ff >= cfg_t_cmd && state_ff == ST_STOPPING) begin
                num = E_TO_SHUT;
            end else if (cmd_wait_ff && cmd_cnt_ff >= cfg_t_cmd && state_ff == ST_READY) begin
                num = E_TO_DISV;
            end else begin
                can = 1'b0;
                if (run && cfg_qs_en && lk.quick_start && qs_cnt_ff >= QS_LIM) begin
                    num = E_QS_LONG;
                end else if (state_ff == ST_TRAVEL && lk.quick_start && !qs_d_ff) begin
                    num = E_QS_TRAV;
                end else if (state_ff == ST_TRAVEL && cfg_mask_799 && rel_d_ff && !lk.drive_release_input) begin
                    num = E_RELEASE;
                end else begin
                    hit = 1'b0;
                end
            end
        end
    end

    // ******************************
    // drive state machine
    // ******************************
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_STARTUP:       if (su_cnt_ff == STARTUP_CYC) nxt_state = ST_DISABLED;
            ST_DISABLED:      if (cv && lk.cmd == CMD_SHUTDOWN) nxt_state = ST_READY;
            ST_READY: begin
                if (cv && lk.cmd == CMD_SWITCH_ON) nxt_state = ST_ON;
                else if (cv && lk.cmd == CMD_DISABLE_VOLT) nxt_state = ST_DISABLED;
            end
            ST_ON: begin
                if (cv && lk.cmd == CMD_ENABLE_OP) nxt_state = ST_TRAVEL;
                else if (cv && lk.cmd == CMD_SHUTDOWN) nxt_state = ST_READY;
            end
            ST_TRAVEL:        if (cv && lk.cmd == CMD_DISABLE_OP) nxt_state = ST_STOPPING;
            ST_STOPPING:      if (cv && lk.cmd == CMD_SHUTDOWN) nxt_state = ST_READY;
            ST_STOP_DELAY: begin
                if (dly_cnt_ff >= STOP_DLY_CYC - 32'h0000_0001)
                    nxt_state = can_err_ff ? ST_RELEASE_CHECK : ST_DISABLED;
            end
            ST_RELEASE_CHECK: if (cv && lk.cmd == CMD_FAULT_RESET) nxt_state = ST_DISABLED;
            ST_FATAL:         if (dly_cnt_ff >= OFF_LIM) nxt_state = ST_WAIT_OFF;
            default:          nxt_state = state_ff;
        endcase
        if (hit) nxt_state = fatal ? ST_FATAL : ST_STOP_DELAY;
    end
    logic [9:0] tag_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff   <= ST_STARTUP;
            can_err_ff <= 1'b0;
            tag_ff     <= '0;
        end else begin
            state_ff <= nxt_state;
            if (hit) begin
                can_err_ff <= can;
                tag_ff     <= num;
            end
        end
    end

    // ******************************
    // timers
    // ******************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            su_cnt_ff  <= '0;
            dly_cnt_ff <= '0;
        end else begin
            if (state_ff == ST_STARTUP) su_cnt_ff <= su_cnt_ff + 4'h1;
            // 905 counts 60 s in fatal; other fatal codes simply stay there
            if (state_ff != nxt_state) dly_cnt_ff <= '0;
            else if (state_ff == ST_STOP_DELAY || (state_ff == ST_FATAL && tag_ff == E_HW_SW))
                dly_cnt_ff <= dly_cnt_ff + 32'h0000_0001;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            qs_cnt_ff  <= '0;
            hbc_cnt_ff <= '0;
            hbe_cnt_ff <= '0;
        end else begin
            qs_cnt_ff  <= lk.quick_start ? qs_cnt_ff + {31'h0, qs_cnt_ff != QS_LIM} : '0;
            hbc_cnt_ff <= lk.hb_ctrl ? '0 : hbc_cnt_ff + 32'h0000_0001;
            hbe_cnt_ff <= henc_p ? '0 : hbe_cnt_ff + 32'h0000_0001;
        end
    end
    // command timeout: armed by travel end, disable op and shutdown of the stop phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_wait_ff <= 1'b0;
            cmd_cnt_ff  <= '0;
            enc_info_ff <= 1'b0;
        end else begin
            if (cv && lk.cmd == CMD_ENC_INFO) enc_info_ff <= 1'b1;
            if (hit || state_ff != nxt_state) begin
                cmd_cnt_ff  <= '0;
                cmd_wait_ff <= !hit && (nxt_state == ST_STOPPING || state_ff == ST_STOPPING);
            end else begin
                if (state_ff == ST_TRAVEL && tend_p) cmd_wait_ff <= 1'b1;
                if (cmd_wait_ff) cmd_cnt_ff <= cmd_cnt_ff + 32'h0000_0001;
            end
        end
    end
    // brake-resistor load over a fixed window; a trip mid-window still counts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_cnt_ff <= '0;
            ovl_cnt_ff <= '0;
        end else if (win_cnt_ff >= OVL_WIN - 32'h0000_0001) begin
            win_cnt_ff <= '0;
            ovl_cnt_ff <= '0;
        end else begin
            win_cnt_ff <= win_cnt_ff + 32'h0000_0001;
            ovl_cnt_ff <= ovl_cnt_ff + {31'h0, bload_s};
        end
    end

    // ******************************
    // outputs
    // ******************************
    logic [9:0] err_ff;
    logic       new_ff, off_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_ff <= '0;
            new_ff <= 1'b0;
            off_ff <= 1'b0;
        end else begin
            new_ff <= hit;
            if (hit) err_ff <= num;
            off_ff <= nxt_state == ST_FATAL || nxt_state == ST_WAIT_OFF || nxt_state == ST_STOP_DELAY;
        end
    end
    assign lk.err_code = err_ff;
    assign lk.err_new  = new_ff;
    assign lk.state    = state_ff;
    assign drive_off   = off_ff;
endmodule

// ### verilog/lfsup_control.sv
// control end: apb-driven lift control commanding the drive supervisor
`timescale 1ns/10ps
module lfsup_control import lfsup_pkg::*; (
    // apb
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // interrupt
    output logic             irq,
    // link to the drive
    lfsup_link_if.ctl        lk
);
    // ******************************
    // apb slave, one wait state
    // ******************************
    logic [31:0] rd_ff, hbper_ff;
    logic        rdy_ff, err_ff, irq_ff;
    logic [2:0]  ctrl_ff, ist_ff, imask_ff;
    logic        acc, wr;
    logic [31:0] rval;
    logic        bad;
    assign acc = psel && penable && rdy_ff;
    assign wr  = acc && pwrite && !err_ff;
    always_comb begin
        rval = '0;
        bad  = 1'b0;
        if (paddr == A_CTRL) rval = {29'h0, ctrl_ff};
        else if (paddr == A_CMD) rval = '0;
        else if (paddr == A_HBPER) rval = hbper_ff;
        else if (paddr == A_STAT) rval = {18'h0, lk.state, lk.err_code};
        else if (paddr == A_ISTAT) rval = {29'h0, ist_ff};
        else if (paddr == A_IMASK) rval = {29'h0, imask_ff};
        else bad = 1'b1;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdy_ff <= 1'b0;
            err_ff <= 1'b0;
            rd_ff  <= '0;
        end else begin
            rdy_ff <= psel && penable && !rdy_ff;
            err_ff <= psel && penable && !rdy_ff && bad;
            if (psel && penable && !rdy_ff) rd_ff <= pwrite ? 32'h0000_0000 : rval;
        end
    end
    assign prdata  = rd_ff;
    assign pready  = rdy_ff;
    assign pslverr = err_ff;

    // ******************************
    // control registers and commands
    // ******************************
    logic       cv_ff;
    lfsup_cmd_t cmd_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff  <= '0;
            hbper_ff <= HBPER_RST;
            imask_ff <= '0;
            cv_ff    <= 1'b0;
            cmd_ff   <= CMD_NONE;
        end else begin
            cv_ff <= wr && paddr == A_CMD;
            if (wr && paddr == A_CMD) cmd_ff <= lfsup_cmd_t'(pwdata[2:0]);
            if (wr && paddr == A_CTRL) ctrl_ff <= pwdata[2:0];
            if (wr && paddr == A_HBPER) hbper_ff <= pwdata;
            if (wr && paddr == A_IMASK) imask_ff <= pwdata[2:0];
        end
    end
    assign lk.quick_start         = ctrl_ff[0];
    assign lk.drive_release_input = ctrl_ff[1];
    assign lk.cmd_valid           = cv_ff;
    assign lk.cmd                 = cmd_ff;

    // ******************************
    // heartbeat generator
    // ******************************
    logic [31:0] hb_cnt_ff;
    logic        hb_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hb_cnt_ff <= '0;
            hb_ff     <= 1'b0;
        end else begin
            hb_ff <= 1'b0;
            if (!ctrl_ff[2]) begin
                hb_cnt_ff <= '0;
            end else if (hb_cnt_ff >= hbper_ff - 32'h0000_0001) begin
                hb_cnt_ff <= '0;
                hb_ff     <= 1'b1;
            end else begin
                hb_cnt_ff <= hb_cnt_ff + 32'h0000_0001;
            end
        end
    end
    assign lk.hb_ctrl = hb_ff;

    // ******************************
    // interrupts: set wins over clear
    // ******************************
    logic [2:0] ev;
    assign ev = {lk.state == ST_RELEASE_CHECK, lk.state == ST_FATAL, lk.err_new};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ist_ff <= '0;
            irq_ff <= 1'b0;
        end else begin
            ist_ff <= (ist_ff & ~((wr && paddr == A_ISTAT) ? pwdata[2:0] : 3'h0)) | ev;
            irq_ff <= |(ist_ff & imask_ff);
        end
    end
    assign irq = irq_ff;
endmodule

// ### test/lfsup_chk.sv
// checker: link-level assertions of the drive fault supervisor
`timescale 1ns/10ps
module lfsup_chk import lfsup_pkg::*; (
    // clock and reset
    input wire logic         pclk,
    input wire logic         presetn,
    // link signals
    input wire logic         quick_start,
    input wire logic         drive_release_input,
    input wire logic         hb_ctrl,
    input wire logic         cmd_valid,
    input wire lfsup_cmd_t   cmd,
    input wire logic [9:0]   err_code,
    input wire logic         err_new,
    input wire lfsup_state_t state
);
    // ******************************
    // stop delay length counter
    // ******************************
    logic [31:0] dly_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            dly_ff <= 32'h0000_0000;
        else if (state == ST_STOP_DELAY)
            dly_ff <= dly_ff + 32'h0000_0001;
        else
            dly_ff <= 32'h0000_0000;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_fatal_sticky: assert property (
        state inside {ST_FATAL, ST_WAIT_OFF} |=> state inside {ST_FATAL, ST_WAIT_OFF}) else $error("fatal left");
    a_waitoff_hold: assert property (
        state == ST_WAIT_OFF |=> state == ST_WAIT_OFF) else $error("wait-off left");
    a_relchk_hold: assert property (
        state == ST_RELEASE_CHECK && !(cmd_valid && cmd == CMD_FAULT_RESET)
        |=> state inside {ST_RELEASE_CHECK, ST_FATAL}) else $error("release check left early");
    a_relchk_exit: assert property (
        state == ST_RELEASE_CHECK && cmd_valid && cmd == CMD_FAULT_RESET
        |=> state inside {ST_DISABLED, ST_FATAL}) else $error("fault reset ignored");
    // a fatal fault may cut the stop delay short
    a_delay_len: assert property (
        $fell(state == ST_STOP_DELAY) && state != ST_FATAL |-> dly_ff == STOP_DLY_CYC) else $error("stop delay length");
    a_code_latch: assert property (
        $changed(err_code) |-> err_new) else $error("error code changed without pulse");
    a_qs_travel: assert property (
        state == ST_TRAVEL && $rose(quick_start) |=> err_new && err_code == E_QS_TRAV) else $error("no 781");
    a_order_err: assert property (
        cmd_valid && state == ST_DISABLED && cmd inside {CMD_SWITCH_ON, CMD_ENABLE_OP, CMD_DISABLE_OP}
        |=> err_new && err_code == E_ORDER) else $error("no 820");
    a_cmd_pulse: assert property (
        cmd_valid |=> !cmd_valid) else $error("command strobe too long");
endmodule

// ### test/lift_drive_fault_supervisor_tb.sv
// testbench: control and drive ends of the fault supervisor joined over the link
`timescale 1ns/10ps
module lift_drive_fault_supervisor_tb import lfsup_pkg::*; ;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        pready, pslverr, irq, perr, doff;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    logic        cmon = 1'b1, fbu = 1'b1, brk = 1'b1, hwf = 1'b0, tend = 1'b0;
    logic        mask799 = 1'b1, posm = 1'b0, henc = 1'b0, bload = 1'b0;
    logic [31:0] hbmin = 32'h0000_0010, hbmax = 32'h0000_00C8, tcmd = 32'h0000_0040;
    int          err_total = 0, num_checks = 0, cyc = 0;
    lfsup_link_if lk ();
    // long counts shortened so the run stays brief
    lfsup_device #(.QS_LIM(32'h0000_0032), .OFF_LIM(32'h0000_0032), .OVL_WIN(32'h0000_00C8),
        .OVL_RATE(32'h0000_0028)) i_lfsup_device (.pclk(pclk), .presetn(presetn), .lk(lk),
        .cfg_qs_en(1'b1), .cfg_mask_799(mask799), .cfg_pos_mode(posm), .cfg_hb_min(hbmin), .cfg_hb_max(hbmax),
        .cfg_t_cmd(tcmd), .chopper_monitor_input(cmon), .fbu_contact(fbu), .brk_contact(brk), .hw_fault(hwf),
        .hb_enc(henc), .travel_end(tend), .brake_load(bload), .drive_off(doff));
    lfsup_control i_lfsup_control (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .lk(lk));
    lfsup_chk i_lfsup_chk (.pclk(pclk), .presetn(presetn), .quick_start(lk.quick_start),
        .drive_release_input(lk.drive_release_input), .hb_ctrl(lk.hb_ctrl), .cmd_valid(lk.cmd_valid),
        .cmd(lk.cmd), .err_code(lk.err_code), .err_new(lk.err_new), .state(lk.state));
    initial begin
        forever #25 pclk = ~pclk;
    end
    // ******************************
    // shared tasks
    // ******************************
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            test_done;
        end
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    // read data sampled before the edge's own updates land
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic cmd(input lfsup_cmd_t c);
        apb(1'b1, A_CMD, 32'(c));
    endtask
    task automatic ex(input lfsup_state_t s, input logic [9:0] e);
        apb(1'b0, A_STAT, 32'h0000_0000);
        chk("state", 32'(q[13:10]), 32'(s));
        chk("error", 32'(q[9:0]), 32'(e));
    endtask
    task automatic r8(input logic [9:0] e);
        ex(ST_STOP_DELAY, e);
        repeat (1100) @(posedge pclk);
        ex(ST_RELEASE_CHECK, e);
        cmd(CMD_FAULT_RESET);
        ex(ST_DISABLED, e);
    endtask
    task automatic r7(input logic [9:0] e);
        ex(ST_STOP_DELAY, e);
        repeat (1100) @(posedge pclk);
        ex(ST_DISABLED, e);
    endtask
    task automatic trav(input logic [9:0] e);
        cmd(CMD_SHUTDOWN);
        cmd(CMD_SWITCH_ON);
        ex(ST_ON, e);
        cmd(CMD_ENABLE_OP);
        ex(ST_TRAVEL, e);
        tend <= 1'b1;
        repeat (4) @(posedge pclk);
        tend <= 1'b0;
    endtask
    task automatic rst(input logic c, input logic p, input logic b);
        presetn <= 1'b0;
        cmon <= c;
        fbu <= p;
        brk <= b;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (8) @(posedge pclk);
    endtask
    // ******************************
    // scenarios
    // ******************************
    task automatic t_regs;
        apb(1'b0, A_HBPER, 32'h0000_0000);
        chk("hbper", q, HBPER_RST);
        apb(1'b0, 8'h18, 32'h0000_0000);
        chk("pslverr", 32'(perr), 32'h0000_0001);
        apb(1'b1, A_HBPER, 32'h0000_0064);
        apb(1'b1, A_CTRL, 32'h0000_0006);
        ex(ST_DISABLED, 10'h000);
        $display("test regs done");
    endtask
    task automatic t_cycle;
        trav(10'h000);
        cmd(CMD_DISABLE_OP);
        ex(ST_STOPPING, 10'h000);
        cmd(CMD_SHUTDOWN);
        ex(ST_READY, 10'h000);
        cmd(CMD_DISABLE_VOLT);
        ex(ST_DISABLED, 10'h000);
        $display("test cycle done");
    endtask
    task automatic t_order;
        apb(1'b1, A_IMASK, 32'h0000_0004);
        cmd(CMD_ENABLE_OP);
        ex(ST_STOP_DELAY, E_ORDER);
        chk("irq masked", 32'(irq), 32'h0000_0000);
        chk("drive off", 32'(doff), 32'h0000_0001);
        repeat (1100) @(posedge pclk);
        ex(ST_RELEASE_CHECK, E_ORDER);
        chk("irq", 32'(irq), 32'h0000_0001);
        cmd(CMD_FAULT_RESET);
        apb(1'b1, A_ISTAT, 32'h0000_0007);
        apb(1'b0, A_ISTAT, 32'h0000_0000);
        chk("istat", 32'(q[2]), 32'h0000_0000);
        chk("irq clear", 32'(irq), 32'h0000_0000);
        $display("test order done");
    endtask
    task automatic t_travel_faults;
        trav(E_ORDER);
        repeat (100) @(posedge pclk);
        r8(E_TO_DISOP);
        trav(E_TO_DISOP);
        apb(1'b1, A_CTRL, 32'h0000_0007);
        apb(1'b1, A_CTRL, 32'h0000_0006);
        r7(E_QS_TRAV);
        apb(1'b1, A_CTRL, 32'h0000_0007);
        repeat (80) @(posedge pclk);
        apb(1'b1, A_CTRL, 32'h0000_0006);
        r7(E_QS_LONG);
        trav(E_QS_LONG);
        apb(1'b1, A_CTRL, 32'h0000_0004);
        apb(1'b1, A_CTRL, 32'h0000_0006);
        r7(E_RELEASE);
        $display("test travel faults done");
    endtask
    task automatic t_fatal;
        apb(1'b1, A_CTRL, 32'h0000_0002);
        repeat (300) @(posedge pclk);
        ex(ST_STOP_DELAY, E_HB);
        hwf <= 1'b1;
        repeat (10) @(posedge pclk);
        ex(ST_FATAL, E_HW_SW);
        cmd(CMD_FAULT_RESET);
        ex(ST_FATAL, E_HW_SW);
        repeat (60) @(posedge pclk);
        ex(ST_WAIT_OFF, E_HW_SW);
        hwf <= 1'b0;
        rst(1'b1, 1'b0, 1'b1);
        ex(ST_FATAL, E_FBU);
        rst(1'b1, 1'b1, 1'b0);
        ex(ST_FATAL, E_BRK);
        rst(1'b0, 1'b1, 1'b1);
        ex(ST_FATAL, E_CHOPPER);
        $display("test fatal done");
    endtask
    initial begin
        rst(1'b1, 1'b1, 1'b1);
        t_regs;
        t_cycle;
        t_order;
        t_travel_faults;
        t_fatal;
        test_done;
    end
endmodule
